// ==== bench/csm_peer.sv ====
// Peripheral model standing at the far end of the serial link
`timescale 1ns/1ps
module csm_peer (
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic arm,
  input wire logic [7:0] reply,
  output logic sdi,
  output logic [7:0] got
);
  logic [7:0] sh;
  logic [2:0] bits;
  initial begin
    sdi = 1'b0;
    got = 8'h00;
    bits = 3'h0;
    sh = 8'h00;
  end
  // A new frame reloads the reply byte
  always @(posedge arm) begin
    sh = reply;
    bits = 3'h0;
  end
  always @(negedge sck) begin
    sdi = sh[7];
    sh = {sh[6:0], sh[7]};
  end
  // sample on rise
  // After the eighth bit the line goes to the inverse, so a late sample cannot pass by luck
  always @(posedge sck) begin
    got = {got[6:0], sdo_oe ? sdo : ~got[0]};
    bits = bits + 3'h1;
    if (bits == 3'h0) sdi <= #17 ~sdi;
  end
endmodule : csm_peer

// ==== bench/csm_top_tb.sv ====
// Self-checking bench: register bus, serial transfers and byte buffer of one channel
`timescale 1ns/1ps
module csm_top_tb;
  localparam logic [15:0] BASE = {csm_pkg::MODE_IDX_CH0[13:0], 2'b00};
  logic clk, resetn, aw_valid, w_valid, b_ready, ar_valid, r_ready, sck_in, tmr2, tmr3, arm;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, sck_out, sck_oe, so, so_oe, si, port_fn;
  logic sck_prev;
  logic [15:0] aw_addr, ar_addr;
  logic [31:0] w_data, r_data, rdv;
  logic [1:0] b_resp, r_resp, rsp;
  logic [7:0] reply, got;
  int err_total, n_tests, cyc, half_seen, hcnt, togs;

  csm_top #(.CHAN(0)) u_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
    .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready), .s_axi_rdata(r_data),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
    .serial_clock_pin_in(sck_in), .serial_clock_pin_out(sck_out),
    .serial_clock_pin_oe(sck_oe), .serial_out_pin_out(so), .serial_out_pin_oe(so_oe),
    .serial_in_pin(si), .timer_two_output(tmr2), .timer_three_output(tmr3),
    .port_function(port_fn));
  csm_peer u_peer (.sck(sck_oe ? sck_out : sck_in), .sdo(so), .sdo_oe(so_oe), .arm(arm),
    .reply(reply), .sdi(si), .got(got));

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    aw_addr <= a;
    w_data <= {24'h000000, d};
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
    end while (!b_valid);
    rsp = b_resp;
    b_ready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
    end while (!r_valid);
    rdv = r_data;
    rsp = r_resp;
    r_ready <= 1'b0;
  endtask : rd

  task automatic t_reset;
    rd(BASE);
    chk("mode reset", rdv, 32'h00000000);
    rd(BASE + 16'h4);
    chk("clksel reset", rdv, 32'h00000000);
    rd(BASE + 16'h8);
    chk("shift reset", rdv, 32'h00000000);
    chk("idle pins", {port_fn, sck_oe, so_oe}, 32'h4);
  endtask : t_reset

  task automatic t_regs;
    wr(BASE, 8'hFF);
    rd(BASE);
    chk("mode byte", rdv, 32'h00000087);
    wr(BASE + 16'h14, 8'h84);
    rd(BASE);
    chk("mode clear", rdv, 32'h00000003);
    wr(BASE + 16'h10, 8'h80);
    rd(BASE);
    chk("mode set", rdv, 32'h00000083);
    chk("serial pins", port_fn, 1'b0);
    wr(BASE, 8'h00);
    wr(BASE + 16'h4, 8'hFF);
    rd(BASE + 16'h4);
    chk("clksel top", rdv, 32'h00000001);
    wr(BASE + 16'h4, 8'h00);
    wr(BASE + 16'h20, 8'h5A);
    chk("bad write", rsp, csm_pkg::RESP_SLVERR);
    rd(BASE + 16'h20);
    chk("bad read", rsp, csm_pkg::RESP_SLVERR);
  endtask : t_regs

  // One frame with a given clock code; ro picks receive-only
  task automatic xfer(input logic [2:0] code, input logic ro, input logic [7:0] tx,
      input logic [7:0] pb);
    reply <= pb;
    arm <= 1'b1;
    wr(BASE + 16'h4, {7'h00, code[2]});
    wr(BASE, {1'b1, 4'h0, ro, code[1:0]});
    arm <= 1'b0;
    if (ro) rd(BASE + 16'h8);
    else wr(BASE + 16'h8, tx);
    repeat (4) @(posedge clk);
    // Bench plays the far clock when the external pin is selected
    if (code == 3'b000) repeat (16) begin
      repeat (4) @(posedge clk);
      sck_in <= ~sck_in;
    end
    do rd(BASE + 16'hC); while (rdv[0] !== 1'b0);
    chk("out enable", so_oe, !ro);
    chk("clock enable", sck_oe, code != 3'b000);
    if (!ro) chk("peer got", got, tx);
    rd(BASE + 16'h8);
    chk("rx byte", rdv, {24'h000000, pb});
    wr(BASE, 8'h00);
  endtask : xfer

  task automatic t_codes;
    logic [2:0] c [6] = '{3'b010, 3'b011, 3'b110, 3'b111, 3'b001, 3'b000};
    int h [5] = '{4, 8, 16, 32, 10};
    for (int i = 0; i < 6; i++) begin
      xfer(c[i], 1'b0, 8'hA5 ^ i[7:0], 8'h3C + i[7:0]);
      if (i < 5) chk("half period", half_seen, h[i]);
    end
    xfer(3'b010, 1'b1, 8'h00, 8'hC3);
  endtask : t_codes

  task automatic t_bad;
    int t0;
    for (int i = 4; i < 6; i++) begin
      wr(BASE + 16'h4, 8'h01);
      wr(BASE, {6'h20, i[1:0]});
      t0 = togs;
      wr(BASE + 16'h8, 8'h66);
      repeat (100) @(posedge clk);
      chk("no clock", togs, t0);
      wr(BASE, 8'h00);
    end
  endtask : t_bad

  task automatic t_abort;
    wr(BASE + 16'h4, 8'h01);
    wr(BASE, 8'h83);
    wr(BASE + 16'h8, 8'h96);
    repeat (200) @(posedge clk);
    rd(BASE + 16'hC);
    chk("mid busy", rdv[0], 1'b1);
    wr(BASE, 8'h00);
    rd(BASE + 16'hC);
    chk("abort status", rdv & 32'hF1, 32'h0);
    chk("pins to port", {port_fn, sck_oe, so_oe}, 32'h4);
  endtask : t_abort

  // Fill the buffer while stopped, then let it drain back to back
  task automatic t_fifo;
    wr(BASE + 16'h4, 8'h00);
    wr(BASE, 8'h02);
    for (int i = 0; i < 16; i++) wr(BASE + 16'h8, i[7:0] ^ 8'h5A);
    rd(BASE + 16'hC);
    chk("fifo full", rdv & 32'h1F07, 32'h1002);
    wr(BASE, 8'h82);
    do rd(BASE + 16'hC); while ((rdv & 32'h5) !== 32'h4);
    chk("last byte", got, 8'h55);
    wr(BASE, 8'h00);
  endtask : t_fifo

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Timer levels, clock half-period monitor and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 10 == 9) tmr2 <= ~tmr2;
    if (cyc % 3 == 2) tmr3 <= ~tmr3;
    sck_prev <= sck_out;
    if (sck_out !== sck_prev) begin
      half_seen <= hcnt;
      hcnt <= 1;
      togs <= togs + 1;
    end else hcnt <= hcnt + 1;
    if (cyc == 40000) begin
      err_total++;
      stop_test;
    end
  end

  initial begin
    {resetn, aw_valid, w_valid, b_ready, ar_valid, r_ready, tmr2, tmr3, arm} = 9'h000;
    sck_in = 1'b1;
    aw_addr = 16'h0000;
    ar_addr = 16'h0000;
    w_data = 32'h00000000;
    reply = 8'h00;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_regs;
    t_codes;
    t_bad;
    t_abort;
    t_fifo;
    stop_test;
  end
endmodule : csm_top_tb

// ==== include/csm_pkg.sv ====
// Shared constants and types for the clocked serial mode control block
package csm_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [31:0] MODE_IDX_CH0 = 32'hFFFFF2A2;
  localparam logic [31:0] MODE_IDX_CH1 = 32'hFFFFF2B2;
  localparam logic [31:0] MODE_IDX_CH3 = 32'hFFFFF2D2;
  localparam int ADDR_W = 16;
  // Offsets of the other registers from the mode register address
  localparam logic [15:0] OFS_MODE = 16'h0000;
  localparam logic [15:0] OFS_CLKSEL = 16'h0004;
  localparam logic [15:0] OFS_DATA = 16'h0008;
  localparam logic [15:0] OFS_STATUS = 16'h000C;
  localparam logic [15:0] OFS_SET = 16'h0010;
  localparam logic [15:0] OFS_CLR = 16'h0014;
  // Mode register fields, and the top clock select bit of the clock select register
  localparam int BIT_ENABLE = 7;
  localparam int BIT_RXONLY = 2;
  localparam int BIT_CLK_MID = 1;
  localparam int BIT_CLK_LOW = 0;
  localparam int BIT_CLK_HIGH = 0;
  localparam logic [7:0] MODE_MASK = 8'h87;
  // Values after reset
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CLKSEL_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  // Transfer and buffer sizes
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  // Half periods of the internal clock, as masks of the divider count
  localparam logic [5:0] HALF_MASK_DIV8 = 6'h03;
  localparam logic [5:0] HALF_MASK_DIV16 = 6'h07;
  localparam logic [5:0] HALF_MASK_DIV32 = 6'h0F;
  localparam logic [5:0] HALF_MASK_DIV64 = 6'h1F;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CLK_EXT = 3'b000,
    CLK_TIMER = 3'b001,
    CLK_DIV8 = 3'b010,
    CLK_DIV16 = 3'b011,
    CLK_BAD4 = 3'b100,
    CLK_BAD5 = 3'b101,
    CLK_DIV32 = 3'b110,
    CLK_DIV64 = 3'b111
  } csm_clk_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } csm_state_t;
endpackage : csm_pkg

// ==== src/csm_fifo.sv ====
// Transmit byte buffer with valid/ready on both sides
`timescale 1ns/1ps
module csm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic push, pop;

  // Full and empty come straight from the pointer distance
  assign count = wr_ptr_reg - rd_ptr_reg;
  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr_reg[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer advance
  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage has no reset; only slots below the write pointer are read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end
endmodule : csm_fifo

// ==== src/csm_top.sv ====
// One clocked serial channel: mode registers, AXI4-Lite slave and shift engine
//
// Overview of operation
// - Reset clears the mode register: channel off, transmit/receive mode.
// - Mode register takes byte writes and masked set or clear writes of one or more bits.
// - Enable low stops shifting, clears bit counter, hands pins to port use.
// - Mode bit low: write starts, output driven; high: read starts, output released.
// - Clock code picks external pin, or internal clock over 8, 16, 32, 64.
// - Clock code 001 uses timer two, or timer three on channel one.
// - Separate clock select register holds the top clock select bit.
// - Reset clears the clock select register.
// - A channel is either stopped or running three-wire transfers.
// - Each transfer moves eight bits, MSB first, receiving, and sending together except in receive-only mode.
// - Enabled channel starts on the selected access; shift register resets to zero.
`timescale 1ns/1ps
module csm_top #(
  parameter int CHAN = 0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe,
  input wire logic serial_in_pin,
  input wire logic timer_two_output,
  input wire logic timer_three_output,
  output logic port_function
);
  localparam logic [31:0] MODE_IDX = (CHAN == 1) ? csm_pkg::MODE_IDX_CH1 :
                                     (CHAN == 3) ? csm_pkg::MODE_IDX_CH3 : csm_pkg::MODE_IDX_CH0;
  localparam logic [15:0] BASE_ADDR = {MODE_IDX[13:0], 2'b00};

  // Word address match against one register of this channel
  function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] ofs);
    logic [15:0] target;
    target = BASE_ADDR + ofs;
    return a[15:2] == target[15:2];
  endfunction : reg_hit

  // Internal sources drive the clock pin; the external source is sampled from it
  function automatic logic is_master(input csm_pkg::csm_clk_t c);
    return c != csm_pkg::CLK_EXT;
  endfunction : is_master

  // Half-period mask per divided source, zero where no divider applies
  function automatic logic [5:0] half_mask(input csm_pkg::csm_clk_t c);
    unique case (c)
      csm_pkg::CLK_DIV8: return csm_pkg::HALF_MASK_DIV8;
      csm_pkg::CLK_DIV16: return csm_pkg::HALF_MASK_DIV16;
      csm_pkg::CLK_DIV32: return csm_pkg::HALF_MASK_DIV32;
      csm_pkg::CLK_DIV64: return csm_pkg::HALF_MASK_DIV64;
      default: return 6'h00;
    endcase
  endfunction : half_mask

  logic [7:0] mode_reg, mode_next, clksel_reg, clksel_next;
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [15:0] awaddr_reg, awaddr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  csm_pkg::csm_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic so_reg, so_next, sck_reg, sck_next, ext_prev_reg, tmr_prev_reg;
  logic [5:0] div_cnt_reg, div_cnt_next;
  logic enable, rx_only, master, wr_go, wr_perform, ar_take, rx_trigger;
  logic [7:0] set_bits;
  csm_pkg::csm_clk_t clk_sel;
  logic timer_level, timer_edge, int_tick, fall, rise, busy;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [4:0] fifo_count;

  // top select bit from the clock select register
  assign clk_sel = csm_pkg::csm_clk_t'({clksel_reg[csm_pkg::BIT_CLK_HIGH],
                                        mode_reg[csm_pkg::BIT_CLK_MID],
                                        mode_reg[csm_pkg::BIT_CLK_LOW]});
  assign enable = mode_reg[csm_pkg::BIT_ENABLE];
  assign rx_only = mode_reg[csm_pkg::BIT_RXONLY];
  assign master = is_master(clk_sel);
  assign busy = (st_reg == csm_pkg::ST_SHIFT);
  assign set_bits = w_data_reg[7:0] & csm_pkg::MODE_MASK;

  // Pin ownership follows enable and mode
  // pins to port use when off
  assign port_function = !enable;
  assign serial_clock_pin_oe = enable && master;
  assign serial_out_pin_oe = enable && !rx_only;
  assign serial_clock_pin_out = sck_reg;
  assign serial_out_pin_out = so_reg;

  // Write channel: address and data held separately, either may come first
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
  // transmit data only accepted in transmit/receive mode
  assign fifo_in_valid = wr_go && reg_hit(awaddr_reg, csm_pkg::OFS_DATA) && !rx_only
                         && w_strb_reg[0];
  // A full buffer stalls the response, which back-pressures the bus master
  assign wr_perform = wr_go && (!fifo_in_valid || fifo_in_ready);

  always_comb begin
    aw_hold_next = aw_hold_reg;
    awaddr_next = awaddr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    mode_next = mode_reg;
    clksel_next = clksel_reg;
    if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_perform) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = csm_pkg::RESP_OKAY;
      if (reg_hit(awaddr_reg, csm_pkg::OFS_MODE)) begin
        // whole byte write; reserved bits dropped
        if (w_strb_reg[0]) mode_next = set_bits;
      end else if (reg_hit(awaddr_reg, csm_pkg::OFS_SET)) begin
        if (w_strb_reg[0]) mode_next = mode_reg | set_bits;
      end else if (reg_hit(awaddr_reg, csm_pkg::OFS_CLR)) begin
        if (w_strb_reg[0]) mode_next = mode_reg & ~set_bits;
      end else if (reg_hit(awaddr_reg, csm_pkg::OFS_CLKSEL)) begin
        // only a byte-lane write updates it
        if (w_strb_reg[0]) clksel_next = {7'h00, w_data_reg[0]};
      end else if (!reg_hit(awaddr_reg, csm_pkg::OFS_DATA)
                   && !reg_hit(awaddr_reg, csm_pkg::OFS_STATUS)) begin
        bresp_next = csm_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= 16'h0000;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= csm_pkg::RESP_OKAY;
      mode_reg <= csm_pkg::MODE_RESET;
      clksel_reg <= csm_pkg::CLKSEL_RESET;
    end else begin
      aw_hold_reg <= aw_hold_next;
      awaddr_reg <= awaddr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      mode_reg <= mode_next;
      clksel_reg <= clksel_next;
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign ar_take = s_axi_arvalid && !rvalid_reg;
  // a data read is the receive-only trigger
  assign rx_trigger = ar_take && reg_hit(s_axi_araddr, csm_pkg::OFS_DATA) && rx_only;

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      rvalid_next = 1'b1;
      rresp_next = csm_pkg::RESP_OKAY;
      if (reg_hit(s_axi_araddr, csm_pkg::OFS_MODE) || reg_hit(s_axi_araddr, csm_pkg::OFS_SET)
          || reg_hit(s_axi_araddr, csm_pkg::OFS_CLR)) begin
        rdata_next = {24'h000000, mode_reg};
      end else if (reg_hit(s_axi_araddr, csm_pkg::OFS_CLKSEL)) begin
        rdata_next = {24'h000000, clksel_reg};
      end else if (reg_hit(s_axi_araddr, csm_pkg::OFS_DATA)) begin
        rdata_next = {24'h000000, sh_reg};
      end else if (reg_hit(s_axi_araddr, csm_pkg::OFS_STATUS)) begin
        rdata_next = {19'h00000, fifo_count, cnt_reg, 1'b0, !fifo_out_valid, !fifo_in_ready,
                      busy};
      end else begin
        rdata_next = 32'h00000000;
        rresp_next = csm_pkg::RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= csm_pkg::RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Transmit bytes wait here until the engine is free
  csm_fifo #(
    .WIDTH(csm_pkg::DATA_W),
    .DEPTH(csm_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_data(w_data_reg[7:0]),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .count(fifo_count)
  );

  // timer source per channel, each level change is a half period
  assign timer_level = (CHAN == 1) ? timer_three_output : timer_two_output;
  assign timer_edge = timer_level != tmr_prev_reg;
  // divider ticks; prohibited codes give no clock at all
  assign int_tick = (clk_sel == csm_pkg::CLK_TIMER) ? timer_edge :
                    (half_mask(clk_sel) != 6'h00) &&
                    ((div_cnt_reg & half_mask(clk_sel)) == half_mask(clk_sel));
  // Master idles high, falls to shift out; slave follows the pin edges
  assign fall = master ? (int_tick && sck_reg) : (ext_prev_reg && !serial_clock_pin_in);
  assign rise = master ? (int_tick && !sck_reg) : (!ext_prev_reg && serial_clock_pin_in);

  // Shift engine
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    so_next = so_reg;
    sck_next = sck_reg;
    fifo_out_ready = 1'b0;
    div_cnt_next = enable ? div_cnt_reg + 6'h01 : 6'h00;
    if (!enable) begin
      // stopped, counter cleared; no transfers when off
      st_next = csm_pkg::ST_IDLE;
      cnt_next = 4'h0;
      sck_next = 1'b1;
    end else begin
      unique case (st_reg)
        csm_pkg::ST_IDLE: begin
          sck_next = 1'b1;
          // start on the access that fits the mode
          if (!rx_only && fifo_out_valid) begin
            fifo_out_ready = 1'b1;
            sh_next = fifo_out_data;
            so_next = fifo_out_data[7];
            cnt_next = 4'h0;
            st_next = csm_pkg::ST_SHIFT;
          end else if (rx_trigger) begin
            cnt_next = 4'h0;
            st_next = csm_pkg::ST_SHIFT;
          end
        end
        csm_pkg::ST_SHIFT: begin
          // MSB out on fall, input sampled on rise
          if (fall) begin
            if (master) sck_next = 1'b0;
            so_next = sh_reg[7];
          end else if (rise) begin
            if (master) sck_next = 1'b1;
            sh_next = {sh_reg[6:0], serial_in_pin};
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == csm_pkg::BITS_PER_XFER - 4'h1) st_next = csm_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= csm_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= csm_pkg::SHIFT_RESET;
      so_reg <= 1'b0;
      sck_reg <= 1'b1;
      div_cnt_reg <= 6'h00;
      ext_prev_reg <= 1'b1;
      tmr_prev_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      so_reg <= so_next;
      sck_reg <= sck_next;
      div_cnt_reg <= div_cnt_next;
      ext_prev_reg <= serial_clock_pin_in;
      tmr_prev_reg <= timer_level;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_finish;
    $past(enable) && enable && $fell(busy);
  endsequence
  sequence s_rx_start;
    enable && rx_only && !busy && rx_trigger;
  endsequence

  property p_mode_reset;
    !$past(resetn) |-> mode_reg == csm_pkg::MODE_RESET;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode not clear after reset");
  property p_clksel_reset;
    !$past(resetn) |-> clksel_reg == csm_pkg::CLKSEL_RESET;
  endproperty
  a_clksel_reset: assert property (p_clksel_reset) else $error("clksel not clear");
  property p_set_bits;
    wr_perform && w_strb_reg[0] && reg_hit(awaddr_reg, csm_pkg::OFS_SET)
      |=> (mode_reg & $past(set_bits)) == $past(set_bits);
  endproperty
  a_set_bits: assert property (p_set_bits) else $error("bit set lost");
  // Pins follow enable at once; counter and state clear one edge later
  property p_stopped;
    !enable |-> (!serial_clock_pin_oe && !serial_out_pin_oe && port_function)
      ##1 (cnt_reg == 4'h0 && !busy);
  endproperty
  a_stopped: assert property (p_stopped) else $error("disabled channel still active");
  property p_tx_start;
    enable && !rx_only && !busy && fifo_out_valid |=> busy ##0 so_reg == sh_reg[7];
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("write did not start transfer");
  property p_bad_code;
    (clk_sel == csm_pkg::CLK_BAD4 || clk_sel == csm_pkg::CLK_BAD5) |-> !int_tick;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("prohibited code clocked");
  // Judged only while the divider runs untouched for a whole half period
  sequence s_div8_on;
    enable && clk_sel == csm_pkg::CLK_DIV8;
  endsequence
  property p_div8;
    s_div8_on ##0 int_tick ##1 s_div8_on [*4]
      |-> int_tick && !$past(int_tick) && !$past(int_tick, 2) && !$past(int_tick, 3);
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 half period wrong");
  property p_timer;
    clk_sel == csm_pkg::CLK_TIMER && timer_edge |-> int_tick;
  endproperty
  a_timer: assert property (p_timer) else $error("timer edge not used");
  property p_clksel_high;
    wr_perform && w_strb_reg[0] && reg_hit(awaddr_reg, csm_pkg::OFS_CLKSEL)
      |=> clk_sel[2] == $past(w_data_reg[0]);
  endproperty
  a_clksel_high: assert property (p_clksel_high) else $error("select top bit wrong");
  property p_eight;
    s_finish |-> cnt_reg == csm_pkg::BITS_PER_XFER;
  endproperty
  a_eight: assert property (p_eight) else $error("transfer not eight bits");
  property p_rx_start;
    s_rx_start |=> busy && cnt_reg == 4'h0;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("read did not start");
endmodule : csm_top
